// ===== verilog/ftm_pkg.sv
// Package for the frame timing mapper: offsets, field widths, counts.
// Assumes a chip tick arrives from the radio timing pin at chip rate.
package ftm_pkg;
  // Chip and frame geometry
  localparam logic [15:0] CHIPS_PER_FRAME = 16'h9600;
  localparam logic [15:0] CHIP_LAST       = 16'h95FF;
  localparam logic [15:0] CHIP_SHIFT_MAX  = 16'h95FF;
  localparam logic [8:0]  CHIPS_PER_UNIT  = 9'h1DF;
  localparam logic [6:0]  UNIT_LAST       = 7'h4F;
  localparam logic [11:0] FRAME_LAST      = 12'hFFF;
  localparam logic [3:0]  CELL_STEPS_MAX  = 4'h9;
  localparam logic [18:0] STAMP_WRAP      = 19'h5_0000;
  localparam logic [23:0] CHIPS_FRAME_W   = 24'h00_9600;
  localparam logic [23:0] CYCLE_CHIPS     = 24'h96_0000;
  localparam logic [15:0] ROUND_HI_LAST   = 16'h95FF;
  localparam logic [7:0]  ROUND_HALF      = 8'h80;
  // Register byte offsets
  localparam logic [7:0] OFF_CTRL        = 8'h00;
  localparam logic [7:0] OFF_FRAME_SHIFT = 8'h04;
  localparam logic [7:0] OFF_CHIP_SHIFT  = 8'h08;
  localparam logic [7:0] OFF_CELL_DELAY  = 8'h0C;
  localparam logic [7:0] OFF_CONN_IN     = 8'h10;
  localparam logic [7:0] OFF_MAP_DL      = 8'h14;
  localparam logic [7:0] OFF_MAP_UL      = 8'h18;
  localparam logic [7:0] OFF_DL_TIMING   = 8'h1C;
  localparam logic [7:0] OFF_NODE_TIME   = 8'h20;
  localparam logic [7:0] OFF_SYNC_T1     = 8'h24;
  localparam logic [7:0] OFF_SYNC_T2     = 8'h28;
  localparam logic [7:0] OFF_SYNC_T3     = 8'h2C;
  localparam logic [7:0] OFF_STATUS      = 8'h30;
  localparam logic [7:0] OFF_STAMP_NOW   = 8'h34;
  // Reset values
  localparam logic       RST_ENABLE      = 1'b0;
  localparam logic [7:0] RST_BYTE        = 8'h00;
  localparam logic [31:0] RST_WORD       = 32'h0000_0000;
  typedef enum logic [1:0] {ST_IDLE, ST_STAMP, ST_WAIT_ACK} ftm_sync_state_t;
endpackage

// ===== verilog/ftm_stamp_if.sv
// Carrier between the mapper top and its synchronisation stamp unit.
// Same clock on both sides.
`timescale 1ns/10ps
interface ftm_stamp_if;
  logic [18:0] stamp;
  logic        dl_accept;
  logic [18:0] t1;
  logic        busy;
  logic        done;
  modport top  (output stamp, output dl_accept, output t1, input busy, input done);
  modport unit (input stamp, input dl_accept, input t1, output busy, output done);
endinterface

// ===== verilog/ftm_round.sv
// Downlink dedicated-channel offset rounding to a 256-chip boundary.
// Inputs are register values on the same clock; result is registered.
`timescale 1ns/10ps
module ftm_round
  import ftm_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic [7:0]  frame_shift_i,
  input  wire logic [15:0] chip_shift_i,
  output logic      [23:0] rounded_o
);
  logic [23:0] total;
  logic [15:0] hi;
  logic [7:0]  rem;
  logic [15:0] next_hi;
  logic [23:0] next_rounded;

  // Max total fits 24 bits, so no overflow in the product
  assign total = 24'({16'h0000, frame_shift_i} * CHIPS_FRAME_W) + 24'(chip_shift_i); // [R6]
  assign hi    = total[23:8];
  assign rem   = total[7:0];

  always_comb begin
    if (rem >= ROUND_HALF) begin
      next_hi = hi + 16'h0001; // [R8]
    end else begin
      next_hi = hi; // [R7] [R9]
    end
    if ({next_hi, 8'h00} >= CYCLE_CHIPS) begin
      next_rounded = 24'h00_0000; // [R22]
    end else begin
      next_rounded = {next_hi, 8'h00};
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rounded_o <= 24'h00_0000;
    end else begin
      rounded_o <= next_rounded; // [R6]
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  a_round_down: assert property ((rem != 8'h00 && rem < ROUND_HALF)
    |=> rounded_o == {$past(hi), 8'h00}) else $error("round down wrong"); // [R7]
  a_round_up: assert property (rem >= ROUND_HALF |=> rounded_o ==
    (($past(hi) == ROUND_HI_LAST) ? 24'h00_0000 : {$past(hi) + 16'h0001, 8'h00}))
    else $error("round up wrong"); // [R8]
  a_round_exact: assert property (rem == 8'h00 |=> rounded_o == $past(total))
    else $error("exact offset changed"); // [R9]
  a_round_cycle: assert property (rounded_o < CYCLE_CHIPS && rounded_o[7:0] == 8'h00)
    else $error("offset off grid"); // [R22]
  c_round_up: cover property (rem >= ROUND_HALF ##1 rounded_o != 24'h00_0000);
endmodule

// ===== verilog/ftm_sync_stamp.sv
// Node synchronisation frame handling: receive stamp, send stamp, reply.
// Transport acknowledge arrives already synchronised by the top.
`timescale 1ns/10ps
module ftm_sync_stamp
  import ftm_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  ftm_stamp_if.unit        sif,
  input  wire logic        ack_i,
  output logic             ul_valid_o,
  output logic      [18:0] ul_t1_o,
  output logic      [18:0] ul_t2_o,
  output logic      [18:0] ul_t3_o
);
  ftm_sync_state_t state;
  logic            done;

  assign sif.busy = (state != ST_IDLE);
  assign sif.done = done;

  // New downlink frames while a reply is pending are dropped
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state      <= ST_IDLE;
      ul_valid_o <= 1'b0;
      ul_t1_o    <= 19'h0_0000;
      ul_t2_o    <= 19'h0_0000;
      ul_t3_o    <= 19'h0_0000;
      done       <= 1'b0;
    end else begin
      done <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (sif.dl_accept) begin
            ul_t1_o <= sif.t1;    // [R18]
            ul_t2_o <= sif.stamp; // [R12]
            state   <= ST_STAMP;
          end
        end
        ST_STAMP: begin
          ul_t3_o    <= sif.stamp; // [R13]
          ul_valid_o <= 1'b1;      // [R18]
          state      <= ST_WAIT_ACK;
        end
        ST_WAIT_ACK: begin
          if (ack_i) begin
            ul_valid_o <= 1'b0;
            done       <= 1'b1;
            state      <= ST_IDLE;
          end
        end
        default: begin
          state      <= ST_IDLE;
          ul_valid_o <= 1'b0;
        end
      endcase
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  a_rx_stamp: assert property (sif.dl_accept && state == ST_IDLE
    |=> ul_t2_o == $past(sif.stamp)) else $error("receive stamp wrong"); // [R12]
  a_tx_stamp: assert property ($rose(ul_valid_o) |-> ul_t3_o == $past(sif.stamp))
    else $error("send stamp wrong"); // [R13]
  a_reply_timing: assert property (sif.dl_accept && state == ST_IDLE
    |=> !ul_valid_o ##1 ul_valid_o && ul_t1_o == $past(sif.t1, 2))
    else $error("reply late or echo wrong"); // [R18]
  c_reply_done: cover property (ul_valid_o ##[1:20] done);
endmodule

// ===== verilog/ftm_top.sv
// Frame timing mapper top: node frame counter, cell delay, frame number
// mapping, dedicated-channel offset and sync stamps behind an AHB-Lite slave.
// Assumes CHIP_TICK_I and UL_ACK_I are asynchronous pins, one chip tick per chip.
//
// The register addresses and the AHB-Lite register port were left to the implementer.
`timescale 1ns/10ps
// Operation
// R1: Downlink cell frame equals connection frame plus shift
// R2: Connection frame equals cell frame minus shift
// R3: Eight-bit values, all mapping wraps modulo 256
// R4: Controller supplies frame shift, used unchanged
// R5: Chip shift 0 to 38399, one-chip steps
// R6: Shift times 38400 plus chips, rounded to 256
// R7: Remainder 1 to 127 rounds down
// R8: Remainder 128 to 255 rounds up
// R9: Exact multiple of 256 used unchanged
// R10: Cell starts delayed from node counter
// R11: Cell delay 0 to 9 steps of 256
// R12: Capture node receive stamp on downlink frame
// R13: Stamp uplink frame with node send stamp
// R14: Controller stamps downlink frame with send time
// R15: Controller receive stamp stays in the controller
// R16: Default chip link offset 0 to 599
// R17: Default frame link offset 0 to 7
// R18: Reply echoes controller stamp with both node stamps
// R19: Node frame counter counts 0 to 4095, wraps
// R20: Cell frame number follows delayed node counter
// R21: Stamps count eighth-milliseconds modulo 327680, 19 bits
// R22: Rounded offset stays within one 256-frame cycle
module ftm_top
  import ftm_pkg::*;
(
  input  wire logic        CLK_I,
  input  wire logic        RST_N_I,
  input  wire logic        HSEL_I,
  input  wire logic [31:0] HADDR_I,
  input  wire logic [1:0]  HTRANS_I,
  input  wire logic        HWRITE_I,
  input  wire logic [2:0]  HSIZE_I,
  input  wire logic        HREADY_I,
  input  wire logic [31:0] HWDATA_I,
  output logic      [31:0] HRDATA_O,
  output logic             HREADYOUT_O,
  output logic             HRESP_O,
  input  wire logic        CHIP_TICK_I,
  input  wire logic        UL_ACK_I,
  output logic             UL_VALID_O,
  output logic      [18:0] UL_T1_O,
  output logic      [18:0] UL_T2_O,
  output logic      [18:0] UL_T3_O,
  output logic      [11:0] NODE_FRAME_O,
  output logic             CELL_FRAME_START_O,
  output logic      [23:0] DL_TIMING_O
);
  ftm_stamp_if sif ();

  logic        tick_s1;
  logic        tick_s2;
  logic        tick_s3;
  logic        ack_s1;
  logic        ack_s2;
  logic        tick;
  logic        enable;
  logic [15:0] chip_cnt;
  logic [8:0]  unit_chip;
  logic [6:0]  unit_idx;
  logic [11:0] node_frame;
  logic [15:0] next_chip;
  logic [18:0] stamp;
  logic [15:0] delay_chips;
  logic [11:0] cell_frame;
  logic [7:0]  frame_shift;
  logic [15:0] chip_shift;
  logic [3:0]  cell_delay;
  logic [7:0]  conn_in;
  logic [7:0]  map_dl;
  logic [7:0]  map_ul;
  logic [18:0] t1_reg;
  logic        reply_done;
  logic        acc;
  logic        wr_pend;
  logic        rd_pend;
  logic [7:0]  addr_q;
  logic        wr_t1;

  // Pin synchronisers; the edge detector compares the second and third stages
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      tick_s1 <= 1'b0;
      tick_s2 <= 1'b0;
      tick_s3 <= 1'b0;
      ack_s1  <= 1'b0;
      ack_s2  <= 1'b0;
    end else begin
      tick_s1 <= CHIP_TICK_I;
      tick_s2 <= tick_s1;
      tick_s3 <= tick_s2;
      ack_s1  <= UL_ACK_I;
      ack_s2  <= ack_s1;
    end
  end

  assign tick      = tick_s2 & ~tick_s3;
  assign next_chip = (chip_cnt == CHIP_LAST) ? 16'h0000 : chip_cnt + 16'h0001;

  // Node frame counter with eighth-millisecond sub-count
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      chip_cnt   <= 16'h0000;
      unit_chip  <= 9'h000;
      unit_idx   <= 7'h00;
      node_frame <= 12'h000;
    end else if (tick && enable) begin
      chip_cnt <= next_chip;
      if (chip_cnt == CHIP_LAST) begin
        unit_chip  <= 9'h000;
        unit_idx   <= 7'h00;
        node_frame <= (node_frame == FRAME_LAST) ? 12'h000 : node_frame + 12'h001; // [R19]
      end else if (unit_chip == CHIPS_PER_UNIT) begin
        unit_chip <= 9'h000;
        unit_idx  <= (unit_idx == UNIT_LAST) ? 7'h00 : unit_idx + 7'h01;
      end else begin
        unit_chip <= unit_chip + 9'h001;
      end
    end
  end

  // Eighty units per frame, so 4096 frames give 327680 units
  assign stamp = 19'({node_frame, 6'b00_0000}) + 19'({node_frame, 4'b0000})
               + 19'(unit_idx); // [R21]

  // Cell timing lags the node counter by the programmed delay
  assign delay_chips = 16'({cell_delay, 8'h00}); // [R11]
  assign cell_frame  = (chip_cnt >= delay_chips) ? node_frame
                                                 : node_frame - 12'h001; // [R20]

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      CELL_FRAME_START_O <= 1'b0;
      NODE_FRAME_O       <= 12'h000;
    end else begin
      CELL_FRAME_START_O <= tick && enable && (next_chip == delay_chips); // [R10]
      NODE_FRAME_O       <= node_frame;
    end
  end

  // Mapping between connection and cell frame numbers, low 8 bits only
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      map_dl <= RST_BYTE;
      map_ul <= RST_BYTE;
    end else begin
      map_dl <= conn_in + frame_shift;          // [R1] [R3] [R4]
      map_ul <= cell_frame[7:0] - frame_shift;  // [R2] [R3]
    end
  end

  ftm_round u_round (
    .clk_i         (CLK_I),
    .rst_n_i       (RST_N_I),
    .frame_shift_i (frame_shift),
    .chip_shift_i  (chip_shift),
    .rounded_o     (DL_TIMING_O)
  );

  assign sif.stamp     = stamp;
  assign sif.dl_accept = wr_t1;
  assign sif.t1        = HWDATA_I[18:0];

  ftm_sync_stamp u_sync (
    .clk_i      (CLK_I),
    .rst_n_i    (RST_N_I),
    .sif        (sif),
    .ack_i      (ack_s2),
    .ul_valid_o (UL_VALID_O),
    .ul_t1_o    (UL_T1_O),
    .ul_t2_o    (UL_T2_O),
    .ul_t3_o    (UL_T3_O)
  );

  // AHB-Lite slave: writes take no wait, reads insert one wait state
  assign acc   = HSEL_I & HTRANS_I[1] & HREADY_I;
  assign wr_t1 = wr_pend && (addr_q == OFF_SYNC_T1);

  function automatic logic [31:0] read_word(input logic [7:0] a);
    case (a)
      OFF_CTRL:        read_word = {31'h0000_0000, enable};
      OFF_FRAME_SHIFT: read_word = {24'h00_0000, frame_shift};
      OFF_CHIP_SHIFT:  read_word = {16'h0000, chip_shift};
      OFF_CELL_DELAY:  read_word = {28'h000_0000, cell_delay};
      OFF_CONN_IN:     read_word = {24'h00_0000, conn_in};
      OFF_MAP_DL:      read_word = {24'h00_0000, map_dl};
      OFF_MAP_UL:      read_word = {24'h00_0000, map_ul};
      OFF_DL_TIMING:   read_word = {8'h00, DL_TIMING_O};
      OFF_NODE_TIME:   read_word = {4'h0, cell_frame, 4'h0, node_frame};
      OFF_SYNC_T1:     read_word = {13'h0000, t1_reg};
      OFF_SYNC_T2:     read_word = {13'h0000, UL_T2_O};
      OFF_SYNC_T3:     read_word = {13'h0000, UL_T3_O};
      OFF_STATUS:      read_word = {29'h0000_0000, UL_VALID_O, reply_done, sif.busy};
      OFF_STAMP_NOW:   read_word = {13'h0000, stamp};
      default:         read_word = RST_WORD;
    endcase
  endfunction

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      wr_pend     <= 1'b0;
      rd_pend     <= 1'b0;
      addr_q      <= 8'h00;
      HREADYOUT_O <= 1'b1;
      HRESP_O     <= 1'b0;
      HRDATA_O    <= RST_WORD;
    end else begin
      wr_pend     <= acc & HWRITE_I;
      rd_pend     <= acc & ~HWRITE_I;
      HREADYOUT_O <= ~(acc & ~HWRITE_I);
      HRESP_O     <= 1'b0;
      if (acc) begin
        addr_q <= {HADDR_I[7:2], 2'b00};
      end
      if (rd_pend) begin
        HRDATA_O <= read_word(addr_q);
      end
    end
  end

  // Software-written configuration
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      enable      <= RST_ENABLE;
      frame_shift <= RST_BYTE;
      chip_shift  <= 16'h0000;
      cell_delay  <= 4'h0;
      conn_in     <= RST_BYTE;
      t1_reg      <= 19'h0_0000;
    end else if (wr_pend) begin
      case (addr_q)
        OFF_CTRL:        enable      <= HWDATA_I[0];
        OFF_FRAME_SHIFT: frame_shift <= HWDATA_I[7:0]; // [R4]
        OFF_CHIP_SHIFT:  chip_shift  <= (HWDATA_I[15:0] > CHIP_SHIFT_MAX) ? CHIP_SHIFT_MAX
                                                                          : HWDATA_I[15:0]; // [R5]
        OFF_CELL_DELAY:  cell_delay  <= (HWDATA_I[3:0] > CELL_STEPS_MAX) ? CELL_STEPS_MAX
                                                                         : HWDATA_I[3:0]; // [R11]
        OFF_CONN_IN:     conn_in     <= HWDATA_I[7:0];
        OFF_SYNC_T1:     t1_reg      <= HWDATA_I[18:0];
        default: begin
        end
      endcase
    end
  end

  // Reply-done flag: a set in the clearing cycle wins
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      reply_done <= 1'b0;
    end else if (sif.done) begin
      reply_done <= 1'b1;
    end else if (wr_pend && addr_q == OFF_STATUS && HWDATA_I[1]) begin
      reply_done <= 1'b0;
    end
  end

  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);

  a_frame_wrap: assert property (tick && enable && chip_cnt == CHIP_LAST
    && node_frame == FRAME_LAST |=> node_frame == 12'h000)
    else $error("node frame did not wrap"); // [R19]
  a_stamp_range: assert property (stamp < STAMP_WRAP)
    else $error("stamp out of range"); // [R21]
  a_map_down: assert property (1'b1 |=> map_dl == 8'($past(conn_in) + $past(frame_shift)))
    else $error("downlink map wrong"); // [R1]
  a_map_up: assert property (1'b1 |=> 8'(map_ul + $past(frame_shift)) == $past(cell_frame[7:0]))
    else $error("uplink map wrong"); // [R2]
  a_chip_shift: assert property (chip_shift <= CHIP_SHIFT_MAX)
    else $error("chip shift over range"); // [R5]
  a_cell_delay: assert property (cell_delay <= CELL_STEPS_MAX)
    else $error("cell delay over range"); // [R11]
  a_cell_start: assert property (CELL_FRAME_START_O |-> chip_cnt == delay_chips
    && cell_frame == node_frame) else $error("cell start misplaced"); // [R10]
  a_read_wait: assert property (acc && !HWRITE_I |=> !HREADYOUT_O ##1 HREADYOUT_O)
    else $error("read wait wrong");
  c_frame_wrap: cover property (node_frame == FRAME_LAST ##[1:1000] node_frame == 12'h000);
  c_cell_start: cover property (CELL_FRAME_START_O && cell_delay != 4'h0);
  c_sync_reply: cover property (wr_t1 ##2 UL_VALID_O);
endmodule

// ===== verif/ftm_ctrl_model.sv
// Controller-side model: acknowledges each uplink sync reply after a delay.
// Assumes the mapper holds its reply until the acknowledge is seen.
`timescale 1ns/10ps
module ftm_ctrl_model (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic [3:0]  ack_delay_i,
  input  wire logic        ul_valid_i,
  output logic             ack_o,
  output logic      [7:0]  replies_o
);
  logic [3:0]  wait_cnt;
  logic [18:0] ctrl_time;
  logic [18:0] controller_receive_stamp;

  // Own time base; the receive stamp never leaves the model
  always_ff @(posedge clk_i) begin
    ctrl_time <= rst_n_i ? ctrl_time + 19'h0_0001 : 19'h0_0000;
  end

  // Ack held until the reply is withdrawn, so it is never taken twice
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ack_o                    <= 1'b0;
      wait_cnt                 <= 4'h0;
      replies_o                <= 8'h00;
      controller_receive_stamp <= 19'h0_0000;
    end else if (!ul_valid_i) begin
      ack_o    <= 1'b0;
      wait_cnt <= 4'h0;
    end else if (!ack_o && wait_cnt == ack_delay_i) begin
      ack_o                    <= 1'b1;
      replies_o                <= replies_o + 8'h01;
      controller_receive_stamp <= ctrl_time;
    end else if (!ack_o) begin
      wait_cnt <= wait_cnt + 4'h1;
    end
  end
endmodule

// ===== verif/testbench.sv
// Self-checking bench for the frame timing mapper over AHB-Lite.
// Assumes one slave, so hready is the design's own hreadyout.
`timescale 1ns/10ps
module testbench;
  import ftm_pkg::*;
  logic        clk, rst_n, hsel, hwrite, tick, hready, hresp, ul_ack, ul_valid, cell_start;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [18:0] ul_echo, ul_rx, ul_tx;
  logic [11:0] node_frame;
  logic [23:0] dl_timing;
  logic [3:0]  ack_delay;
  logic [7:0]  replies;
  int          bad_count, comparisons, starts;

  initial clk = 1'b0;
  always #5 clk = ~clk;

  ftm_top dut (.CLK_I(clk), .RST_N_I(rst_n), .HSEL_I(hsel), .HADDR_I(haddr),
    .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(3'h2), .HREADY_I(hready),
    .HWDATA_I(hwdata), .HRDATA_O(hrdata), .HREADYOUT_O(hready), .HRESP_O(hresp),
    .CHIP_TICK_I(tick), .UL_ACK_I(ul_ack), .UL_VALID_O(ul_valid), .UL_T1_O(ul_echo),
    .UL_T2_O(ul_rx), .UL_T3_O(ul_tx), .NODE_FRAME_O(node_frame),
    .CELL_FRAME_START_O(cell_start), .DL_TIMING_O(dl_timing));
  ftm_ctrl_model partner (.clk_i(clk), .rst_n_i(rst_n), .ack_delay_i(ack_delay),
    .ul_valid_i(ul_valid), .ack_o(ul_ack), .replies_o(replies));

  // Pulse seen at exactly one edge, since it stands one cycle
  always @(posedge clk) begin
    if (cell_start === 1'b1) starts++;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    int n;
    hsel   <= 1'b1;
    haddr  <= {24'h00_0000, a};
    htrans <= 2'h2;
    hwrite <= wr;
    n = 0;
    do begin @(posedge clk); n++; end while (hready !== 1'b1 && n < 50);
    htrans <= 2'h0;
    hsel   <= 1'b0;
    hwdata <= wd;
    n = 0;
    do begin @(posedge clk); n++; end while (hready !== 1'b1 && n < 50);
    rd = hrdata;
    chk({31'h0000_0000, hresp}, 32'h0000_0000, "response");
    if (n >= 50) begin
      bad_count++;
      $display("unexpected at %0t: bus hang", $time);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string what);
    logic [31:0] x;
    bus(1'b0, a, 32'h0000_0000, x);
    chk(x, exp, what);
  endtask

  // Four cycles per chip keeps the pin two cycles high and two low
  task automatic ticks(input int n);
    repeat (n) begin
      tick <= 1'b1;
      repeat (2) @(posedge clk);
      tick <= 1'b0;
      repeat (2) @(posedge clk);
    end
  endtask

  task automatic t_reset;
    rdc(OFF_CTRL, RST_WORD, "ctrl reset");
    rdc(OFF_FRAME_SHIFT, RST_WORD, "shift reset");
    rdc(OFF_DL_TIMING, RST_WORD, "timing reset");
    wr(8'h3C, 32'hFFFF_FFFF);
    rdc(8'h3C, RST_WORD, "unmapped read");
    $display("test reset done");
  endtask

  task automatic t_map_dl;
    logic [7:0] cn[3] = '{8'hC8, 8'h00, 8'h11};
    logic [7:0] sh[3] = '{8'h64, 8'hFF, 8'h00};
    logic [7:0] m;
    for (int i = 0; i < 3; i++) begin
      wr(OFF_FRAME_SHIFT, {24'h00_0000, sh[i]});
      wr(OFF_CONN_IN, {24'h00_0000, cn[i]});
      m = cn[i] + sh[i];
      rdc(OFF_MAP_DL, {24'h00_0000, m}, "map down");
      rdc(OFF_FRAME_SHIFT, {24'h00_0000, sh[i]}, "shift kept");
    end
    $display("test map down done");
  endtask

  task automatic t_round;
    int fs[8] = '{0, 0, 0, 0, 0, 3, 255, 1};
    int cs[8] = '{1, 127, 128, 255, 512, 200, 38399, 40000};
    int c, full, r, exp;
    for (int i = 0; i < 8; i++) begin
      c = (cs[i] > 38399) ? 38399 : cs[i];
      full = fs[i] * 38400 + c;
      r = full % 256;
      exp = (full - r + ((r >= 128) ? 256 : 0)) % (256 * 38400);
      wr(OFF_FRAME_SHIFT, fs[i]);
      wr(OFF_CHIP_SHIFT, cs[i]);
      rdc(OFF_CHIP_SHIFT, c, "chip shift");
      rdc(OFF_DL_TIMING, exp, "rounded");
      chk({8'h00, dl_timing}, exp, "timing pin");
    end
    $display("test rounding done");
  endtask

  task automatic t_cell;
    wr(OFF_FRAME_SHIFT, 32'h0000_000A);
    wr(OFF_CELL_DELAY, 32'h0000_000F);
    rdc(OFF_CELL_DELAY, 32'h0000_0009, "delay limit");
    wr(OFF_CELL_DELAY, 32'h0000_0002);
    wr(OFF_CTRL, 32'h0000_0001);
    rdc(OFF_NODE_TIME, 32'h0FFF_0000, "cell lags");
    rdc(OFF_MAP_UL, 32'h0000_00F5, "map up");
    starts = 0;
    ticks(511);
    repeat (4) @(posedge clk);
    rdc(OFF_NODE_TIME, 32'h0FFF_0000, "before delay");
    chk(starts, 0, "early start");
    ticks(1);
    repeat (4) @(posedge clk);
    rdc(OFF_NODE_TIME, 32'h0000_0000, "after delay");
    chk(starts, 1, "cell start");
    rdc(OFF_MAP_UL, 32'h0000_00F6, "map up wrap");
    rdc(OFF_STAMP_NOW, 32'h0000_0001, "stamp");
    chk({20'h0_0000, node_frame}, 32'h0000_0000, "node frame");
    $display("test cell delay done");
  endtask

  task automatic t_sync;
    int n;
    for (int i = 0; i < 2; i++) begin
      ack_delay <= (i == 0) ? 4'h0 : 4'h7;
      wr(OFF_SYNC_T1, 32'h0001_2345 + i);
      wr(OFF_SYNC_T1, 32'h0000_0777);
      n = 0;
      while (ul_valid !== 1'b1 && n < 50) begin @(posedge clk); n++; end
      chk({13'h0000, ul_echo}, 32'h0001_2345 + i, "echo");
      chk({13'h0000, ul_rx}, 32'h0000_0001, "rx stamp");
      chk({13'h0000, ul_tx}, 32'h0000_0001, "tx stamp");
      n = 0;
      while (ul_valid !== 1'b0 && n < 50) begin @(posedge clk); n++; end
      chk(n < 50, 1, "reply taken");
      rdc(OFF_SYNC_T2, 32'h0000_0001, "rx reg");
      rdc(OFF_STATUS, 32'h0000_0002, "done set");
      wr(OFF_STATUS, 32'h0000_0002);
      rdc(OFF_STATUS, 32'h0000_0000, "done clear");
      chk(replies, i + 1, "reply count");
    end
    $display("test sync done");
  endtask

  task automatic close_out;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // About 2300 cycles expected; over fifteen times that cuts a hang
  initial begin
    #400_000;
    bad_count++;
    $display("unexpected at %0t: watchdog", $time);
    close_out();
  end

  initial begin
    {rst_n, hsel, hwrite, tick} = 4'h0;
    haddr = 32'h0000_0000;
    hwdata = 32'h0000_0000;
    htrans = 2'h0;
    ack_delay = 4'h0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_reset();
    t_map_dl();
    t_round();
    t_cell();
    t_sync();
    close_out();
  end
endmodule
